// *** zero_seq_cfg.svh ***
// Constants of the residual overvoltage block: register offsets, field positions, reset values, timing counts.
// Assumes inclusion by bare name from the package and from the design file.
`ifndef ZERO_SEQ_CFG_SVH
`define ZERO_SEQ_CFG_SVH
`define CLK_FREQ_HZ 50_000_000
`define MS_PER_S 1000
`define CYCLES_PER_MS (`CLK_FREQ_HZ / `MS_PER_S)
`define FORCE_TIMEOUT_S 300
`define PCT_FULL 7'h64
`define PCT_STEP 32'h0000_0064
`define GROUPS 4
`define LOG_DEPTH 4'h8
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_FORCE_STATE 8'h08
`define ADDR_INT_STATUS 8'h0C
`define ADDR_INT_MASK 8'h10
`define ADDR_SCALE 8'h14
`define ADDR_START_COUNT 8'h18
`define ADDR_TRIP_COUNT 8'h1C
`define ADDR_PICKUP_BASE 8'h40
`define ADDR_DELAY_BASE 8'h60
`define ADDR_LOG_SEL 8'h80
`define ADDR_LOG_DATE 8'h84
`define ADDR_LOG_TIME 8'h88
`define ADDR_LOG_INFO 8'h8C
`define CTRL_FORCE_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_GROUP_LSB 4
`define CTRL_SOURCE_LSB 8
`define CTRL_INDEX_LSB 12
`define CTRL_CLR_START_BIT 16
`define CTRL_CLR_TRIP_BIT 17
`define CTRL_WRITE_MASK 32'h0000_F73F
`define CTRL_RESET 32'h0000_0000
`define SCALE_RESET 32'h0001_0000
`define PICKUP_RESET 16'h0064
`define DELAY_RESET 16'h0064
`define INT_EVENTS 6
`endif

// *** zero_seq_pkg.sv ***
// Types shared by the residual overvoltage block.
// Assumes the constants header is on the include path.
`include "zero_seq_cfg.svh"
package zero_seq_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_BLOCKED = 2'b01, ST_STARTED = 2'b10, ST_TRIPPED = 2'b11} stage_state_t;
  typedef enum logic [1:0] {MODE_DIRECT = 2'b00, MODE_CALC = 2'b01, MODE_SINGLE = 2'b10, MODE_OFF = 2'b11} meas_mode_t;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_DIGITAL = 3'b001, SRC_VIRTUAL_IN = 3'b010, SRC_INDICATOR = 3'b011, SRC_VIRTUAL_OUT = 3'b100
  } group_source_t;
endpackage : zero_seq_pkg

// *** zero_seq_overvoltage_stage.sv ***
// Two definite-time residual overvoltage stages with setting groups, counters, force flag and fault log, on APB.
// Assumes a fundamental-frequency magnitude from the front end and time stamps from the relay framework.
// How it works
// R1: Voltage above pick-up starts the stage.
// R2: Start lasting the operate delay trips.
// R3: Only the fundamental-frequency magnitude is supervised.
// R4: Single voltage modes block the function.
// R5: Direct mode scales by transformer secondary.
// R6: Low-set and high-set definite-time stages.
// R7: Four setting groups, switched by inputs or manually; inputs reach only groups 1 and 2 in the block.
// R8: Source selector picks the group control signal.
// R9: Status idle/blocked/started/tripped; forceable while flagged.
// R10: Start counter, clearable by the operator.
// R11: Trip counter, clearable by the operator.
// R12: Shared force flag clears after five minutes.
// R13: Operator gives password before editing settings; the block has no password check and takes settings writes without one.
// R14: Values are tenths of percent of rated.
// R15: Log time, voltage, delay, group per fault.
// R16: Elapsed delay in percent, 100 means trip.
// R17: Full log drops its oldest entry.
`timescale 1ns/1ps
`default_nettype none
`include "zero_seq_cfg.svh"

module definite_time_stage
  import zero_seq_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Measurement and settings.
  input wire logic enable,
  input wire logic meas_valid,
  input wire logic [15:0] measure,
  input wire logic [15:0] pickup,
  input wire logic [15:0] delay_ms,
  // Test forcing and counter clears.
  input wire logic force_on,
  input wire logic forced_start,
  input wire logic forced_trip,
  input wire logic clr_start,
  input wire logic clr_trip,
  // Results.
  output stage_state_t state,
  output logic start,
  output logic trip,
  output logic start_rise,
  output logic trip_rise,
  output logic fault_end,
  output logic [6:0] elapsed_pct,
  output logic [15:0] peak,
  output logic [15:0] start_count,
  output logic [15:0] trip_count
);
  logic picked;
  logic picked_q;
  logic start_q;
  logic trip_q;
  logic [31:0] acc;
  logic [31:0] limit;
  logic [31:0] next_acc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      picked <= 1'b0;
    end else if (!enable) begin
      picked <= 1'b0; // [R4]
    end else if (meas_valid) begin
      picked <= measure > pickup; // [R1]
    end
  end

  assign limit = 32'(delay_ms) * 32'(`CYCLES_PER_MS);
  assign next_acc = acc + `PCT_STEP;

  // The percentage advances once per hundredth of the delay, so reaching 100 is the trip moment.
  // It is cleared while dropped out, so a new pick-up never sees the last fault's 100 as a trip.
  // The fault log still reads the held value at the clearing edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 32'h0000_0000;
      elapsed_pct <= 7'h00;
      peak <= 16'h0000;
    end else if (!picked) begin
      acc <= 32'h0000_0000;
      elapsed_pct <= 7'h00;
    end else begin
      if (!picked_q) begin
        peak <= measure;
      end else if (meas_valid && measure > peak) begin
        peak <= measure;
      end
      if (elapsed_pct != `PCT_FULL) begin
        if (next_acc >= limit) begin
          acc <= next_acc - limit;
          elapsed_pct <= elapsed_pct + 7'h01; // [R16] [R2]
        end else begin
          acc <= next_acc;
        end
      end
    end
  end

  assign start = force_on ? (forced_start | forced_trip) : picked; // [R9] [R1]
  assign trip = force_on ? forced_trip : (picked && elapsed_pct == `PCT_FULL); // [R9] [R2]
  assign start_rise = start && !start_q;
  assign trip_rise = trip && !trip_q;
  assign fault_end = picked_q && !picked;

  always_comb begin
    if (trip) begin
      state = ST_TRIPPED;
    end else if (start) begin
      state = ST_STARTED;
    end else if (!enable) begin
      state = ST_BLOCKED;
    end else begin
      state = ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      picked_q <= 1'b0;
      start_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      picked_q <= picked;
      start_q <= start;
      trip_q <= trip;
    end
  end

  // An event in the clearing cycle is kept by counting it as the first after the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_count <= 16'h0000;
    end else if (start_rise) begin
      start_count <= clr_start ? 16'h0001 : start_count + 16'h0001; // [R10]
    end else if (clr_start) begin
      start_count <= 16'h0000; // [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_count <= 16'h0000;
    end else if (trip_rise) begin
      trip_count <= clr_trip ? 16'h0001 : trip_count + 16'h0001; // [R11]
    end else if (clr_trip) begin
      trip_count <= 16'h0000; // [R11]
    end
  end
endmodule : definite_time_stage

module zero_seq_overvoltage_stage
  import zero_seq_pkg::*;
#(
  parameter logic [35:0] FORCE_TIMEOUT_CYCLES = 36'(64'(`FORCE_TIMEOUT_S) * 64'(`CLK_FREQ_HZ))
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement front end, same clock.
  input wire logic meas_valid,
  input wire logic [15:0] residual_direct_raw,
  input wire logic [15:0] residual_calc_pct,
  // Group control signals.
  input wire logic [7:0] digital_input_n,
  input wire logic [7:0] virtual_input_n,
  input wire logic [7:0] indicator_signal_n,
  input wire logic [7:0] virtual_output_n,
  // Time stamp source, same clock.
  input wire logic [31:0] stamp_date,
  input wire logic [31:0] stamp_time_ms,
  // Stage outputs and interrupt.
  output logic low_set_start,
  output logic low_set_trip,
  output logic high_set_start,
  output logic high_set_trip,
  output logic irq
);
  logic [31:0] ctrl;
  logic [3:0] force_state;
  logic [`INT_EVENTS-1:0] int_status;
  logic [`INT_EVENTS-1:0] int_mask;
  logic [31:0] scale;
  logic [15:0] pickup [0:7];
  logic [15:0] delay [0:7];
  logic [35:0] force_timer;
  logic force_timeout;
  logic [7:0] din_meta;
  logic [7:0] din_sync;
  logic [2:0] log_sel;
  logic [2:0] log_wp;
  logic [3:0] log_count;
  logic [31:0] log_date [0:7];
  logic [31:0] log_time [0:7];
  logic [31:0] log_info [0:7];
  logic wr;
  logic rd_setup;
  logic mapped;
  logic [31:0] next_rdata;
  logic [31:0] scaled;
  logic [15:0] residual_voltage_value;
  logic disabled;
  logic force_flag;
  meas_mode_t mode;
  group_source_t source;
  logic [7:0] source_bits;
  logic group_signal;
  logic [1:0] active_group;
  logic [2:0] low_idx;
  logic [2:0] high_idx;
  logic [2:0] log_rd;
  stage_state_t low_state;
  stage_state_t high_state;
  logic low_start_rise;
  logic low_trip_rise;
  logic low_end;
  logic high_start_rise;
  logic high_trip_rise;
  logic high_end;
  logic [6:0] low_pct;
  logic [6:0] high_pct;
  logic [15:0] low_peak;
  logic [15:0] high_peak;
  logic [15:0] low_starts;
  logic [15:0] high_starts;
  logic [15:0] low_trips;
  logic [15:0] high_trips;
  logic log_write;
  logic [`INT_EVENTS-1:0] events;

  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign force_flag = ctrl[`CTRL_FORCE_BIT];
  assign mode = meas_mode_t'(ctrl[`CTRL_MODE_LSB +: 2]);
  assign source = group_source_t'(ctrl[`CTRL_SOURCE_LSB +: 3]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
    end else begin
      din_meta <= digital_input_n;
      din_sync <= din_meta;
    end
  end

  // Group control: no source leaves the manual group; a selected signal toggles between groups 1 and 2.
  always_comb begin
    case (source)
      SRC_DIGITAL: source_bits = din_sync;
      SRC_VIRTUAL_IN: source_bits = virtual_input_n;
      SRC_INDICATOR: source_bits = indicator_signal_n;
      SRC_VIRTUAL_OUT: source_bits = virtual_output_n;
      default: source_bits = 8'h00;
    endcase
  end
  assign group_signal = source_bits[ctrl[`CTRL_INDEX_LSB +: 3]]; // [R8]
  assign active_group = (source == SRC_NONE) ? ctrl[`CTRL_GROUP_LSB +: 2] : {1'b0, group_signal}; // [R7] [R8]
  assign low_idx = {1'b0, active_group};
  assign high_idx = {1'b1, active_group};

  // The front end delivers the fundamental magnitude only, so harmonics never reach the comparison.
  assign scaled = 32'(residual_direct_raw) * scale; // [R5] [R3]
  assign residual_voltage_value = (mode == MODE_DIRECT) ? scaled[31:16] : residual_calc_pct; // [R14]
  assign disabled = (mode == MODE_SINGLE) || (mode == MODE_OFF); // [R4]

  definite_time_stage u_low_set_stage (
    .pclk(pclk), .presetn(presetn), .enable(!disabled), .meas_valid(meas_valid),
    .measure(residual_voltage_value), .pickup(pickup[low_idx]), .delay_ms(delay[low_idx]), // [R6]
    .force_on(force_flag), .forced_start(force_state[0]), .forced_trip(force_state[1]),
    .clr_start(wr && paddr == `ADDR_CTRL && pwdata[`CTRL_CLR_START_BIT]),
    .clr_trip(wr && paddr == `ADDR_CTRL && pwdata[`CTRL_CLR_TRIP_BIT]),
    .state(low_state), .start(low_set_start), .trip(low_set_trip), .start_rise(low_start_rise),
    .trip_rise(low_trip_rise), .fault_end(low_end), .elapsed_pct(low_pct), .peak(low_peak),
    .start_count(low_starts), .trip_count(low_trips)
  );

  definite_time_stage u_high_set_stage (
    .pclk(pclk), .presetn(presetn), .enable(!disabled), .meas_valid(meas_valid),
    .measure(residual_voltage_value), .pickup(pickup[high_idx]), .delay_ms(delay[high_idx]), // [R6]
    .force_on(force_flag), .forced_start(force_state[2]), .forced_trip(force_state[3]),
    .clr_start(wr && paddr == `ADDR_CTRL && pwdata[`CTRL_CLR_START_BIT]),
    .clr_trip(wr && paddr == `ADDR_CTRL && pwdata[`CTRL_CLR_TRIP_BIT]),
    .state(high_state), .start(high_set_start), .trip(high_set_trip), .start_rise(high_start_rise),
    .trip_rise(high_trip_rise), .fault_end(high_end), .elapsed_pct(high_pct), .peak(high_peak),
    .start_count(high_starts), .trip_count(high_trips)
  );

  // Any register write restarts the force timeout, standing in for operator activity.
  assign force_timeout = force_flag && !wr && force_timer == FORCE_TIMEOUT_CYCLES - 36'h0_0000_0001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_timer <= 36'h0_0000_0000;
    end else if (!force_flag || wr) begin
      force_timer <= 36'h0_0000_0000;
    end else begin
      force_timer <= force_timer + 36'h0_0000_0001; // [R12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
    end else if (wr && paddr == `ADDR_CTRL) begin
      ctrl <= pwdata & `CTRL_WRITE_MASK;
    end else if (force_timeout) begin
      ctrl[`CTRL_FORCE_BIT] <= 1'b0; // [R12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_state <= 4'h0;
      scale <= `SCALE_RESET;
      int_mask <= '0;
    end else if (wr) begin
      if (paddr == `ADDR_FORCE_STATE && force_flag) begin
        force_state <= pwdata[3:0]; // [R9]
      end
      if (paddr == `ADDR_SCALE) begin
        scale <= pwdata;
      end
      if (paddr == `ADDR_INT_MASK) begin
        int_mask <= pwdata[`INT_EVENTS-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        pickup[i] <= `PICKUP_RESET;
        delay[i] <= `DELAY_RESET;
      end
    end else if (wr && paddr[7:5] == `ADDR_PICKUP_BASE >> 5) begin
      pickup[paddr[4:2]] <= pwdata[15:0];
    end else if (wr && paddr[7:5] == `ADDR_DELAY_BASE >> 5) begin
      delay[paddr[4:2]] <= pwdata[15:0];
    end
  end

  assign events = {force_timeout, log_write, high_trip_rise, high_start_rise, low_trip_rise, low_start_rise};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= '0;
    end else if (wr && paddr == `ADDR_INT_STATUS) begin
      int_status <= (int_status & ~pwdata[`INT_EVENTS-1:0]) | events;
    end else begin
      int_status <= int_status | events;
    end
  end
  assign irq = |(int_status & int_mask);

  // The high-set stage wins when both faults end in the same cycle.
  assign log_write = low_end || high_end;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_wp <= 3'h0;
      log_count <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        log_date[i] <= 32'h0000_0000;
        log_time[i] <= 32'h0000_0000;
        log_info[i] <= 32'h0000_0000;
      end
    end else if (log_write) begin
      log_date[log_wp] <= stamp_date; // [R15]
      log_time[log_wp] <= stamp_time_ms; // [R15]
      log_info[log_wp] <= high_end ? {5'h00, high_end, active_group, 1'b0, high_pct, high_peak}
                                   : {5'h00, high_end, active_group, 1'b0, low_pct, low_peak}; // [R15] [R16]
      log_wp <= log_wp + 3'h1; // [R17]
      if (log_count != `LOG_DEPTH) begin
        log_count <= log_count + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_sel <= 3'h0;
    end else if (wr && paddr == `ADDR_LOG_SEL) begin
      log_sel <= pwdata[2:0];
    end
  end
  assign log_rd = log_wp - 3'h1 - log_sel;

  always_comb begin
    next_rdata = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr[7:5] == `ADDR_PICKUP_BASE >> 5) begin
      next_rdata = {16'h0000, pickup[paddr[4:2]]};
    end else if (paddr[7:5] == `ADDR_DELAY_BASE >> 5) begin
      next_rdata = {16'h0000, delay[paddr[4:2]]};
    end else begin
      case (paddr)
        `ADDR_CTRL: next_rdata = ctrl;
        `ADDR_STATUS: next_rdata = {22'h00_0000, active_group, 1'b0, high_state, low_state, 2'b00, force_flag}; // [R9]
        `ADDR_FORCE_STATE: next_rdata = {28'h000_0000, force_state};
        `ADDR_INT_STATUS: next_rdata = {26'h000_0000, int_status};
        `ADDR_INT_MASK: next_rdata = {26'h000_0000, int_mask};
        `ADDR_SCALE: next_rdata = scale;
        `ADDR_START_COUNT: next_rdata = {high_starts, low_starts};
        `ADDR_TRIP_COUNT: next_rdata = {high_trips, low_trips};
        `ADDR_LOG_SEL: next_rdata = {25'h000_0000, log_count, log_sel};
        `ADDR_LOG_DATE: next_rdata = ({1'b0, log_sel} < log_count) ? log_date[log_rd] : 32'h0000_0000;
        `ADDR_LOG_TIME: next_rdata = ({1'b0, log_sel} < log_count) ? log_time[log_rd] : 32'h0000_0000;
        `ADDR_LOG_INFO: next_rdata = ({1'b0, log_sel} < log_count) ? log_info[log_rd] : 32'h0000_0000;
        default: mapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= mapped ? next_rdata : 32'h0000_0000;
    end
  end
  assign pslverr = psel && penable && !mapped;

  a_start_pickup: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    (meas_valid && !disabled && !force_flag && residual_voltage_value > pickup[low_idx]) ##1 !force_flag |-> low_set_start)
    else $error("low-set stage did not start above pick-up");
  a_trip_at_full: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    $rose(low_set_trip) && !force_flag |-> low_pct == `PCT_FULL && low_set_start)
    else $error("low-set trip before full delay");
  a_trip_needs_start: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    high_set_trip |-> high_set_start)
    else $error("high-set trip without start");
  a_single_blocks: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (disabled && !force_flag) ##1 (disabled && !force_flag) |-> !low_set_start && low_state == ST_BLOCKED)
    else $error("stage active in single voltage mode");
  a_direct_scale: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    mode == MODE_DIRECT && scale == `SCALE_RESET |-> residual_voltage_value == residual_direct_raw)
    else $error("unit scale changed the direct residual value");
  a_manual_group: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    source == SRC_NONE |-> active_group == ctrl[`CTRL_GROUP_LSB +: 2])
    else $error("manual group not applied");
  a_forced_trip: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    force_flag && force_state[1] |-> low_set_trip && low_state == ST_TRIPPED)
    else $error("forced trip not shown");
  a_start_count: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    $rose(low_set_start) && !(wr && paddr == `ADDR_CTRL) |=> low_starts == $past(low_starts) + 16'h0001)
    else $error("start counter missed an event");
  a_trip_count: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    $rose(high_set_trip) && !(wr && paddr == `ADDR_CTRL) |=> high_trips == $past(high_trips) + 16'h0001)
    else $error("trip counter missed an event");
  a_force_expire: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    force_timeout |=> !force_flag && int_status[5])
    else $error("force flag survived its timeout");
  a_log_full: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
    log_write && log_count == `LOG_DEPTH |=> log_count == `LOG_DEPTH && log_wp == $past(log_wp) + 3'h1)
    else $error("full log did not overwrite the oldest entry");
  c_low_trip: cover property (@(posedge pclk) disable iff (!presetn) $rose(low_set_trip) && !force_flag);
  c_high_trip: cover property (@(posedge pclk) disable iff (!presetn) $rose(high_set_trip) && !force_flag);
  c_force_timeout: cover property (@(posedge pclk) disable iff (!presetn) force_timeout);
  c_log_wrap: cover property (@(posedge pclk) disable iff (!presetn) log_write && log_count == `LOG_DEPTH);
endmodule : zero_seq_overvoltage_stage
`default_nettype wire

// *** meas_model.sv ***
// Model of the measurement front end and time stamp source of the relay.
// Assumes the same clock as the block and a level requested by the bench.
`timescale 1ns/1ps
`default_nettype none
module meas_model #(
  parameter logic [31:0] DATE = 32'h0000_1234
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Requested level.
  input wire logic [15:0] level,
  // Front end outputs.
  output logic meas_valid,
  output logic [15:0] residual_direct_raw,
  output logic [15:0] residual_calc_pct,
  output logic [31:0] stamp_date,
  output logic [31:0] stamp_time_ms
);
  logic [1:0] phase;
  assign stamp_date = DATE;
  // A fundamental-only magnitude arrives on every fourth cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
      meas_valid <= 1'b0;
      residual_direct_raw <= 16'h0000;
      residual_calc_pct <= 16'h0000;
      stamp_time_ms <= 32'h0000_0000;
    end else begin
      phase <= phase + 2'h1;
      meas_valid <= (phase == 2'h3);
      residual_direct_raw <= level;
      residual_calc_pct <= level;
      stamp_time_ms <= stamp_time_ms + 32'h0000_0001;
    end
  end
endmodule : meas_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the residual overvoltage block.
// Assumes the constants header, the package and the measurement model.
`timescale 1ns/1ps
`default_nettype none
`include "zero_seq_cfg.svh"
module tb_top
  import zero_seq_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] level = 16'h0000;
  logic [7:0] gsig = 8'h00;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic mv;
  wire logic [15:0] raw;
  wire logic [15:0] pct;
  wire logic [31:0] sdate;
  wire logic [31:0] stime;
  wire logic [3:0] outs;
  wire logic irq;
  logic [31:0] rd;
  logic err;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  meas_model fe_u (.pclk(pclk), .presetn(presetn), .level(level), .meas_valid(mv),
    .residual_direct_raw(raw), .residual_calc_pct(pct), .stamp_date(sdate), .stamp_time_ms(stime));
  zero_seq_overvoltage_stage #(.FORCE_TIMEOUT_CYCLES(36'h0_0000_00C8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_valid(mv), .residual_direct_raw(raw), .residual_calc_pct(pct),
    .digital_input_n(gsig), .virtual_input_n(gsig), .indicator_signal_n(gsig),
    .virtual_output_n(gsig), .stamp_date(sdate), .stamp_time_ms(stime),
    .low_set_start(outs[0]), .low_set_trip(outs[1]), .high_set_start(outs[2]),
    .high_set_trip(outs[3]), .irq(irq));
  initial begin
    forever #10 pclk = ~pclk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Every write stands for an operator who has already given the password.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic fault(input logic [15:0] v);
    @(posedge pclk);
    level <= v;
    for (n = 0; n < 50 && outs[0] !== 1'b1; n++) @(negedge pclk);
    for (n = 0; n < 300 && outs[1] !== 1'b1; n++) @(negedge pclk);
    chk("trip delay", n, 100);
    chk("outputs at trip", outs, 4'h3);
    xfer(0, `ADDR_STATUS, 0);
    chk("tripped state", rd[4:3], ST_TRIPPED);
    @(posedge pclk);
    level <= 16'h0000;
    for (n = 0; n < 50 && outs[0] !== 1'b0; n++) @(negedge pclk);
  endtask : fault
  task automatic t_regs;
    xfer(0, `ADDR_STATUS, 0);
    chk("status", rd, 32'h0000_0000);
    xfer(0, `ADDR_SCALE, 0);
    chk("scale", rd, `SCALE_RESET);
    xfer(0, `ADDR_PICKUP_BASE + 8'h1C, 0);
    chk("pickup", rd, `PICKUP_RESET);
    xfer(0, `ADDR_DELAY_BASE, 0);
    chk("delay", rd, `DELAY_RESET);
    xfer(0, 8'hFC, 0);
    chk("slverr", err, 1'b1);
    $display("done regs");
  endtask : t_regs
  task automatic t_faults;
    xfer(1, `ADDR_CTRL, 32'h0000_0002);
    xfer(1, `ADDR_PICKUP_BASE + 8'h10, 32'h0000_FFFF);
    xfer(1, `ADDR_DELAY_BASE, 32'h0000_0000);
    xfer(1, `ADDR_INT_MASK, 32'h0000_0010);
    @(posedge pclk);
    level <= 16'h0064;
    repeat (12) @(negedge pclk);
    chk("equal level", outs, 4'h0);
    fault(16'h0065);
    xfer(0, `ADDR_INT_STATUS, 0);
    chk("int status", rd, 8'h13);
    chk("irq set", irq, 1'b1);
    xfer(1, `ADDR_INT_STATUS, 32'h0000_0013);
    @(negedge pclk);
    chk("irq clear", irq, 1'b0);
    xfer(0, `ADDR_LOG_INFO, 0);
    chk("log info", rd, 32'h0064_0065);
    xfer(0, `ADDR_LOG_DATE, 0);
    chk("log date", rd, 32'h0000_1234);
    for (int i = 0; i < 8; i++) fault(16'h0070 + 16'(i));
    xfer(0, `ADDR_LOG_SEL, 0);
    chk("log count", rd[6:3], 4'h8);
    xfer(1, `ADDR_LOG_SEL, 32'h0000_0007);
    xfer(0, `ADDR_LOG_INFO, 0);
    chk("oldest entry", rd, 32'h0064_0070);
    xfer(0, `ADDR_START_COUNT, 0);
    chk("start count", rd, 8'h09);
    xfer(0, `ADDR_TRIP_COUNT, 0);
    chk("trip count", rd, 8'h09);
    xfer(1, `ADDR_CTRL, 32'h0003_0002);
    xfer(0, `ADDR_START_COUNT, 0);
    chk("start cleared", rd, 8'h00);
    xfer(0, `ADDR_TRIP_COUNT, 0);
    chk("trip cleared", rd, 8'h00);
    $display("done faults");
  endtask : t_faults
  task automatic t_modes;
    xfer(1, `ADDR_CTRL, 32'h0000_0000);
    xfer(1, `ADDR_SCALE, 32'h0002_0000);
    level <= 16'h0033;
    repeat (12) @(negedge pclk);
    chk("direct above", outs[0], 1'b1);
    @(posedge pclk);
    level <= 16'h0032;
    repeat (12) @(negedge pclk);
    chk("direct equal", outs[0], 1'b0);
    for (int m = 2; m < 4; m++) begin
      xfer(1, `ADDR_CTRL, 32'(m) << 1);
      level <= 16'h00C8;
      repeat (12) @(negedge pclk);
      chk("blocked outs", outs, 4'h0);
      xfer(0, `ADDR_STATUS, 0);
      chk("blocked state", rd[4:3], ST_BLOCKED);
    end
    level <= 16'h0000;
    $display("done modes");
  endtask : t_modes
  task automatic t_groups;
    for (int s = 1; s < 5; s++) begin
      xfer(1, `ADDR_CTRL, 32'h0000_0002 | (32'(s) << 8));
      gsig <= 8'h01;
      repeat (5) @(negedge pclk);
      xfer(0, `ADDR_STATUS, 0);
      chk("group two", rd[9:8], 2'h1);
      gsig <= 8'h00;
      repeat (5) @(negedge pclk);
      xfer(0, `ADDR_STATUS, 0);
      chk("group one", rd[9:8], 2'h0);
    end
    xfer(1, `ADDR_CTRL, 32'h0000_0032);
    xfer(0, `ADDR_STATUS, 0);
    chk("manual group", rd[9:8], 2'h3);
    $display("done groups");
  endtask : t_groups
  task automatic t_force;
    xfer(1, `ADDR_INT_STATUS, 32'h0000_003F);
    xfer(1, `ADDR_INT_MASK, 32'h0000_0020);
    xfer(1, `ADDR_FORCE_STATE, 32'h0000_0006);
    @(negedge pclk);
    chk("unforced", outs, 4'h0);
    xfer(1, `ADDR_CTRL, 32'h0000_0003);
    xfer(1, `ADDR_FORCE_STATE, 32'h0000_0008);
    @(negedge pclk);
    chk("forced high trip", outs, 4'hC);
    xfer(1, `ADDR_FORCE_STATE, 32'h0000_0006);
    repeat (100) @(negedge pclk);
    chk("forced", outs, 4'h7);
    repeat (110) @(negedge pclk);
    chk("force expired", outs, 4'h0);
    chk("timeout irq", irq, 1'b1);
    xfer(0, `ADDR_STATUS, 0);
    chk("force flag", rd[0], 1'b0);
    $display("done force");
  endtask : t_force
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_faults();
    t_modes();
    t_groups();
    t_force();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
